/* adc_host_model.sv */
`timescale 1ns/1ps
module adc_host_model (
  input  wire logic sdo_oe_in,
  input  wire logic sdo_in,
  output logic      cs_b_out,
  output logic      sck_out,
  output logic      sdi_out
);
  wire logic sdo_line;
  // External pull-up on the shared data return line
  assign sdo_line = sdo_oe_in ? sdo_in : 1'b1;
  initial begin
    cs_b_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
  end
  // Framed transfer, clock runs only inside the frame
  task automatic xfer(input logic [15:0] bits, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    cs_b_out = 1'b0;
    #13;
    for (int i = 0; i < n; i++) begin
      sdi_out = bits[15-i];
      #32;
      sck_out = 1'b1;
      #32;
      if (i >= 8) rd = {rd[6:0], sdo_line};
      sck_out = 1'b0;
    end
    #32;
    cs_b_out = 1'b1;
    #40;
  endtask
  // Clock pulses with the port deselected
  task automatic stray();
    repeat (4) begin
      #32;
      sck_out = 1'b1;
      #32;
      sck_out = 1'b0;
    end
  endtask
  // Static levels for the parallel strap
  task automatic set_pins(input logic cs, input logic sck, input logic sdi);
    cs_b_out = cs;
    sck_out = sck;
    sdi_out = sdi;
  endtask
endmodule

/* adc_iface_top.sv */
`timescale 1ns/1ps
`include "adc_map.svh"
// Summary of operation
// - Strap low: chip select, SCK, SDI, SDO serial
// - Strap high: pins are static mode inputs
// - Shift SDI only while chip select low
// - Sample SDI on rising SCK
// - Readback bits driven on SDO per falling SCK
// - SDO open drain, pulls low only
// - Parallel: chip select low disables stabilizer
// - Parallel: SCK picks CMOS or high-current LVDS
// - Parallel: SDI high enters sleep
// - Conversion starts on rising positive encode
// - Full rate: 14 lines, top line MSB
// - Full rate: at phase 0, data moves on clock falling edge
// - Negative output clock inverts positive
// - Range flag high on over or underflow
// - DDR: even bits clock low, odd high
// - Serial: stabilizer from clock register bit
module adc_iface_top (
  input  wire logic                 SYS_CLK_IN,
  input  wire logic                 RST_B_IN,
  input  wire logic                 PROG_MODE_SELECT_IN,
  input  wire logic                 CS_B_IN,
  input  wire logic                 SCK_IN,
  input  wire logic                 SDI_IN,
  input  wire logic                 ENCODE_IN_POS_IN,
  input  wire logic                 ENCODE_IN_NEG_IN,
  input  wire logic [`SAMPLE_W-1:0] SAMPLE_DATA_IN,
  input  wire logic                 SAMPLE_OVER_IN,
  input  wire logic                 SAMPLE_UNDER_IN,
  output logic                      SDO_OUT,
  output logic                      SDO_OE_OUT,
  output logic [`SAMPLE_W-1:0]      DATA_OUT,
  output logic                      RANGE_FLAG_OUT,
  output logic                      OUT_CLOCK_POS_OUT,
  output logic                      OUT_CLOCK_NEG_OUT,
  output logic                      DCS_EN_OUT,
  output logic                      SLEEP_OUT,
  output logic                      DDR_MODE_OUT,
  output logic                      LVDS_MODE_OUT,
  output logic                      LVDS_HICUR_OUT
);

  // Pin order inside the synchroniser vector
  localparam int P_ENC_NEG = 0;
  localparam int P_ENC_POS = 1;
  localparam int P_SDI     = 2;
  localparam int P_SCK     = 3;
  localparam int P_CS_B    = 4;
  localparam int P_PMS     = 5;

  logic [`PIN_W-1:0]     pin_raw;
  logic [`PIN_W-1:0]     pin_sync;
  logic [`CFG_W-1:0]     cfg_link;
  logic [`CFG_W-1:0]     cfg_sync;
  logic [`CFG_W-1:0]     cfg_prev_reg;
  logic [`CFG_W-1:0]     cfg_hold_reg;
  logic [`CFG_W-1:0]     cfg_hold_next;
  logic                  cfg_settled;
  logic                  sdo_pull_link;
  adc_pkg::cfg_s         cfg_ser;
  adc_pkg::cfg_s         cfg_par;
  adc_pkg::cfg_s         cfg_eff;
  logic                  parallel_mode;
  logic                  ddr_mode;
  logic                  lvds_mode;

  logic                  enc_level;
  logic                  enc_prev_reg;
  logic                  enc_rise;
  logic                  enc_fall;

  adc_pkg::sample_s      pipe_reg [`PIPE_LAT];
  adc_pkg::sample_s      pipe_src [`PIPE_LAT];
  adc_pkg::sample_s      sample_now;
  adc_pkg::sample_s      pipe_head;

  logic [`SAMPLE_W-1:0]  held_word_reg;
  logic [`SAMPLE_W-1:0]  held_word_next;
  logic [`SAMPLE_W-1:0]  stage_reg;
  logic [`SAMPLE_W-1:0]  stage_next;
  logic [`SAMPLE_W-1:0]  ddr_even_word;
  logic [`SAMPLE_W-1:0]  ddr_odd_word;
  logic                  range_stage_reg;
  logic                  range_stage_next;
  logic                  clk_raw_reg;
  logic                  clk_raw_next;
  logic [`PHASE_TAPS-2:0] clk_hist_reg;
  logic [`PHASE_TAPS-1:0] clk_taps;
  logic                  clk_tap;

  // Even-numbered bits of a sample, packed into the shared lines
  function automatic logic [`HALF_W-1:0] even_bits(
    input logic [`SAMPLE_W-1:0] w
  );
    for (int k = 0; k < `HALF_W; k++)
      even_bits[k] = w[2*k];
  endfunction

  // Odd-numbered bits of a sample, packed into the shared lines
  function automatic logic [`HALF_W-1:0] odd_bits(
    input logic [`SAMPLE_W-1:0] w
  );
    for (int k = 0; k < `HALF_W; k++)
      odd_bits[k] = w[2*k+1];
  endfunction

  // Strap, serial and encode pins pass two flops before system-clock logic reads them; the serial port takes its pins directly
  assign pin_raw[P_ENC_NEG] = ENCODE_IN_NEG_IN;
  assign pin_raw[P_ENC_POS] = ENCODE_IN_POS_IN;
  assign pin_raw[P_SDI]     = SDI_IN;
  assign pin_raw[P_SCK]     = SCK_IN;
  assign pin_raw[P_CS_B]    = CS_B_IN;
  assign pin_raw[P_PMS]     = PROG_MODE_SELECT_IN;

  sync_bits #(
    .WIDTH (`PIN_W)
  ) u_pin_sync (
    .clk_in   (SYS_CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     (pin_raw),
    .q_out    (pin_sync)
  );

  // Serial port on the SCK domain; chip select frames it
  spi_mode_port u_spi (
    .sck_in       (SCK_IN),
    .cs_b_in      (CS_B_IN),
    .sdi_in       (SDI_IN),
    .rst_b_in     (RST_B_IN),
    .cfg_out      (cfg_link),
    .sdo_pull_out (sdo_pull_link)
  );

  // Register fields are quasi-static; crossed in two clocks, held word updates after four
  sync_bits #(
    .WIDTH (`CFG_W)
  ) u_cfg_sync (
    .clk_in   (SYS_CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     (cfg_link),
    .q_out    (cfg_sync)
  );

  // Word taken only after two equal synced samples;
  // a word caught mid-resolution never sets a mode
  assign cfg_settled   = cfg_sync == cfg_prev_reg;
  assign cfg_hold_next = cfg_settled ? cfg_sync : cfg_hold_reg;

  // Settle filter on the crossed register word
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cfg_prev_reg <= `CFG_RST;
      cfg_hold_reg <= `CFG_RST;
    end else begin
      cfg_prev_reg <= cfg_sync;
      cfg_hold_reg <= cfg_hold_next;
    end
  end

  // Strap selects the mode source
  assign parallel_mode = pin_sync[P_PMS];
  assign cfg_ser       = cfg_hold_reg;

  // Parallel mode: the three pins become static controls
  assign cfg_par.dcs_en     = pin_sync[P_CS_B];
  assign cfg_par.mode       = pin_sync[P_SCK]
                              ? adc_pkg::OUT_LVDS_DDR
                              : adc_pkg::OUT_CMOS_FULL;
  assign cfg_par.lvds_hicur = 1'b1;
  assign cfg_par.sleep      = pin_sync[P_SDI];
  assign cfg_par.clk_phase  = 2'h0;

  assign cfg_eff   = parallel_mode ? cfg_par : cfg_ser;
  assign ddr_mode  = cfg_eff.mode == adc_pkg::OUT_CMOS_DDR
                  || cfg_eff.mode == adc_pkg::OUT_LVDS_DDR;
  assign lvds_mode = cfg_eff.mode == adc_pkg::OUT_LVDS_DDR;

  // Open drain readback; never driven in parallel mode
  assign SDO_OUT    = 1'b0;
  assign SDO_OE_OUT = sdo_pull_link && !parallel_mode;

  // Encode edges; single-ended ties the negative input low
  assign enc_level = pin_sync[P_ENC_POS] && !pin_sync[P_ENC_NEG];
  assign enc_rise  = enc_level && !enc_prev_reg;
  assign enc_fall  = !enc_level && enc_prev_reg;

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN)
      enc_prev_reg <= 1'b0;
    else
      enc_prev_reg <= enc_level;
  end

  // Converted sample with its range condition
  assign sample_now.data  = SAMPLE_DATA_IN;
  assign sample_now.range = SAMPLE_OVER_IN || SAMPLE_UNDER_IN;

  // Stage zero loads the core word, later stages the one before
  assign pipe_src[0] = sample_now;

  // Pipeline advances once per conversion; cleared in sleep
  // Flush in sleep keeps stale pipeline words off the pins; uncleared held_word_reg feeds DDR's first odd half after wake-up
  genvar s;
  generate
    for (s = 0; s < `PIPE_LAT; s++) begin : g_pipe
      if (s > 0) begin : g_link
        assign pipe_src[s] = pipe_reg[s-1];
      end
      always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN)
          pipe_reg[s] <= '0;
        else if (cfg_eff.sleep)
          pipe_reg[s] <= '0;
        else if (enc_rise)
          pipe_reg[s] <= pipe_src[s];
      end
    end
  endgenerate

  assign pipe_head = pipe_reg[`PIPE_LAT-1];

  // Shared-line words for double data rate
  assign ddr_even_word = {{`HALF_W{1'b0}}, even_bits(held_word_next)};
  assign ddr_odd_word  = {{`HALF_W{1'b0}}, odd_bits(held_word_reg)};

  // Output word, flag and raw clock selection
  assign held_word_next = enc_fall ? pipe_head.data : held_word_reg;

  assign stage_next =
      cfg_eff.sleep         ? {`SAMPLE_W{1'b0}} :
      enc_fall && ddr_mode  ? ddr_even_word :
      enc_fall              ? pipe_head.data :
      enc_rise && ddr_mode  ? ddr_odd_word :
                              stage_reg;

  assign range_stage_next =
      cfg_eff.sleep ? 1'b0 :
      enc_fall      ? pipe_head.range :
                      range_stage_reg;

  assign clk_raw_next =
      cfg_eff.sleep ? 1'b0 :
      enc_fall      ? 1'b0 :
      enc_rise      ? 1'b1 :
                      clk_raw_reg;

  // Output stage registers
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      held_word_reg   <= {`SAMPLE_W{1'b0}};
      stage_reg       <= {`SAMPLE_W{1'b0}};
      range_stage_reg <= 1'b0;
      clk_raw_reg     <= 1'b0;
    end else begin
      held_word_reg   <= held_word_next;
      stage_reg       <= stage_next;
      range_stage_reg <= range_stage_next;
      clk_raw_reg     <= clk_raw_next;
    end
  end

  // Output clock phase delay taps, one system cycle each
  assign clk_taps = {clk_hist_reg, clk_raw_reg};
  assign clk_tap  = clk_taps[cfg_eff.clk_phase];

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN)
      clk_hist_reg <= '0;
    else
      clk_hist_reg <= clk_taps[`PHASE_TAPS-2:0];
  end

  // Pin-facing flops: data and clock leave together at phase 0
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      DATA_OUT          <= {`SAMPLE_W{1'b0}};
      RANGE_FLAG_OUT    <= 1'b0;
      OUT_CLOCK_POS_OUT <= 1'b0;
      OUT_CLOCK_NEG_OUT <= 1'b1;
    end else begin
      DATA_OUT          <= stage_reg;
      RANGE_FLAG_OUT    <= range_stage_reg;
      OUT_CLOCK_POS_OUT <= clk_tap;
      OUT_CLOCK_NEG_OUT <= !clk_tap;
    end
  end

  // Effective mode status for the analog side
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      DCS_EN_OUT     <= 1'b0;
      SLEEP_OUT      <= 1'b0;
      DDR_MODE_OUT   <= 1'b0;
      LVDS_MODE_OUT  <= 1'b0;
      LVDS_HICUR_OUT <= 1'b0;
    end else begin
      DCS_EN_OUT     <= cfg_eff.dcs_en;
      SLEEP_OUT      <= cfg_eff.sleep;
      DDR_MODE_OUT   <= ddr_mode;
      LVDS_MODE_OUT  <= lvds_mode;
      LVDS_HICUR_OUT <= lvds_mode && cfg_eff.lvds_hicur;
    end
  end

endmodule

/* adc_iface_top_monitor.sv */
`timescale 1ns/1ps
module adc_iface_top_monitor (
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic PROG_MODE_SELECT_IN,
  input wire logic CS_B_IN,
  input wire logic SCK_IN,
  input wire logic SDI_IN,
  input wire logic ENCODE_IN_POS_IN,
  input wire logic SDO_OUT,
  input wire logic SDO_OE_OUT,
  input wire logic RANGE_FLAG_OUT,
  input wire logic OUT_CLOCK_POS_OUT,
  input wire logic OUT_CLOCK_NEG_OUT,
  input wire logic DCS_EN_OUT,
  input wire logic SLEEP_OUT,
  input wire logic LVDS_MODE_OUT,
  input wire logic LVDS_HICUR_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Strap high and one pin steady long enough to cross
  sequence s_par_held(logic pin);
    (PROG_MODE_SELECT_IN && $stable(pin)) [*5];
  endsequence
  // Encode pin edge of a given polarity while awake
  sequence s_enc_edge(logic lvl);
    (ENCODE_IN_POS_IN == lvl) && $changed(ENCODE_IN_POS_IN) && !SLEEP_OUT;
  endsequence
  a_clk_inverse: assert property (
    OUT_CLOCK_NEG_OUT == !OUT_CLOCK_POS_OUT)
    else $error("Output clock pair not complementary");
  a_sdo_pull_only: assert property (
    SDO_OUT == 1'b0)
    else $error("Serial data output driven high");
  a_sdo_cs_free: assert property (
    CS_B_IN |-> !SDO_OE_OUT)
    else $error("Serial data output pulled while deselected");
  a_par_no_sdo: assert property (
    PROG_MODE_SELECT_IN [*4] |-> !SDO_OE_OUT)
    else $error("Serial data output pulled in parallel mode");
  a_par_dcs: assert property (
    s_par_held(CS_B_IN) |-> DCS_EN_OUT == CS_B_IN)
    else $error("Stabilizer does not follow select pin");
  a_par_lvds: assert property (
    s_par_held(SCK_IN) |-> LVDS_MODE_OUT == SCK_IN && LVDS_HICUR_OUT == SCK_IN)
    else $error("Output mode does not follow clock pin");
  a_par_sleep: assert property (
    s_par_held(SDI_IN) |-> SLEEP_OUT == SDI_IN)
    else $error("Sleep does not follow data pin");
  a_enc_rise: assert property (
    s_enc_edge(1'b1) |-> ##[4:7] OUT_CLOCK_POS_OUT)
    else $error("Output clock did not rise after encode rise");
  a_enc_fall: assert property (
    s_enc_edge(1'b0) |-> ##[4:7] !OUT_CLOCK_POS_OUT)
    else $error("Output clock did not fall after encode fall");
  a_clk_held: assert property (
    $stable(ENCODE_IN_POS_IN) [*8] |-> $stable(OUT_CLOCK_POS_OUT))
    else $error("Output clock moved without encode edge");
  a_sleep_quiet: assert property (
    SLEEP_OUT [*3] |-> !OUT_CLOCK_POS_OUT && !RANGE_FLAG_OUT)
    else $error("Outputs active during sleep");
endmodule
bind adc_iface_top adc_iface_top_monitor u_mon (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN),
  .PROG_MODE_SELECT_IN(PROG_MODE_SELECT_IN), .CS_B_IN(CS_B_IN),
  .SCK_IN(SCK_IN), .SDI_IN(SDI_IN), .ENCODE_IN_POS_IN(ENCODE_IN_POS_IN),
  .SDO_OUT(SDO_OUT), .SDO_OE_OUT(SDO_OE_OUT),
  .RANGE_FLAG_OUT(RANGE_FLAG_OUT), .OUT_CLOCK_POS_OUT(OUT_CLOCK_POS_OUT),
  .OUT_CLOCK_NEG_OUT(OUT_CLOCK_NEG_OUT), .DCS_EN_OUT(DCS_EN_OUT),
  .SLEEP_OUT(SLEEP_OUT), .LVDS_MODE_OUT(LVDS_MODE_OUT),
  .LVDS_HICUR_OUT(LVDS_HICUR_OUT));

/* adc_iface_top_tb.sv */
`timescale 1ns/1ps
module adc_iface_top_tb;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              strap = 1'b0;
  logic              enc = 1'b0;
  logic              ovr = 1'b0;
  logic              und = 1'b0;
  logic [13:0]       din = 14'h0000;
  wire logic         cs_b, sck, sdi, sdo, sdo_oe;
  logic [13:0]       dout, lo_w;
  logic              rng, ckp, ckn, dcs, slp, ddr, lvds, hicur;
  logic              lo_ddr = 1'b0;
  logic [7:0]        rd;
  int                error_cnt = 0;
  int                check_count = 0;
  integer            seed = 32'he6a4905d;
  adc_pkg::sample_s  pipe_q[$];
  adc_pkg::sample_s  exp_q[$];
  adc_pkg::sample_s  e;

  always #5 clk = ~clk;

  adc_iface_top uut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b),
    .PROG_MODE_SELECT_IN(strap), .CS_B_IN(cs_b), .SCK_IN(sck), .SDI_IN(sdi),
    .ENCODE_IN_POS_IN(enc), .ENCODE_IN_NEG_IN(~enc), .SAMPLE_DATA_IN(din),
    .SAMPLE_OVER_IN(ovr), .SAMPLE_UNDER_IN(und), .SDO_OUT(sdo),
    .SDO_OE_OUT(sdo_oe), .DATA_OUT(dout), .RANGE_FLAG_OUT(rng),
    .OUT_CLOCK_POS_OUT(ckp), .OUT_CLOCK_NEG_OUT(ckn), .DCS_EN_OUT(dcs),
    .SLEEP_OUT(slp), .DDR_MODE_OUT(ddr), .LVDS_MODE_OUT(lvds),
    .LVDS_HICUR_OUT(hicur));
  adc_host_model u_host (.sdo_oe_in(sdo_oe), .sdo_in(sdo), .cs_b_out(cs_b),
    .sck_out(sck), .sdi_out(sdi));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Mode levels as {stabilizer, sleep, lvds, high current}
  task automatic chk_mode(input logic [3:0] m);
    chk({12'h000, dcs, slp, lvds, hicur}, {12'h000, m});
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask
  function automatic logic [6:0] pick(logic [13:0] w, int odd);
    for (int k = 0; k < 7; k++) pick[k] = w[2*k+odd];
  endfunction
  // Encode cycles with random words; notes the word due five cycles on
  task automatic encode(input int n);
    adc_pkg::sample_s s;
    logic [31:0] r;
    repeat (n) begin
      r = $random(seed);
      s.data = r[13:0];
      s.range = r[20] | r[21];
      @(posedge clk);
      din <= r[13:0];
      ovr <= r[20];
      und <= r[21] & ~r[20];
      enc <= 1'b1;
      pipe_q.push_back(s);
      if (pipe_q.size() > 5) exp_q.push_back(pipe_q.pop_front());
      repeat (4 + r[23:22]) @(posedge clk);
      enc <= 1'b0;
      repeat (4 + r[25:24]) @(posedge clk);
    end
    settle();
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Low half of each output word
  always @(negedge ckp) begin
    #1;
    lo_w = dout;
    lo_ddr = ddr | lvds;
  end
  // Oldest note against each output clock rise
  always @(posedge ckp) begin
    #1;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk({15'h0000, rng}, {15'h0000, e.range});
      if (ddr | lvds) begin
        chk({2'b00, dout}, {9'h000, pick(e.data, 1)});
        if (lo_ddr) chk({2'b00, lo_w}, {9'h000, pick(e.data, 0)});
      end else begin
        chk({2'b00, dout}, {2'b00, e.data});
        chk({2'b00, lo_w}, {2'b00, e.data});
      end
    end
  end

  initial begin
    #300000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    settle();
    rst_b <= 1'b1;
    @(negedge clk);
    chk_mode(4'b0000);
    chk({15'h0000, ckn}, 16'h0001);
    u_host.xfer(16'h0201, 16, rd);
    settle();
    chk_mode(4'b1000);
    u_host.xfer(16'h8200, 16, rd);
    chk({8'h00, rd}, 16'h0001);
    u_host.xfer(16'h8500, 16, rd);
    chk({8'h00, rd}, 16'h0000);
    u_host.xfer(16'h0200, 10, rd);
    u_host.stray();
    u_host.xfer(16'h8200, 16, rd);
    chk({8'h00, rd}, 16'h0001);
    u_host.xfer(16'h0207, 16, rd);
    settle();
    encode(7);
    u_host.xfer(16'h0080, 16, rd);
    u_host.xfer(16'h8200, 16, rd);
    chk({8'h00, rd}, 16'h0000);
    u_host.xfer(16'h0201, 16, rd);
    encode(12);
    u_host.xfer(16'h0301, 16, rd);
    settle();
    chk({14'h0000, ddr, lvds}, 16'h0002);
    encode(10);
    u_host.xfer(16'h0101, 16, rd);
    settle();
    chk_mode(4'b1100);
    u_host.xfer(16'h0100, 16, rd);
    settle();
    chk_mode(4'b1000);
    pipe_q.delete();
    u_host.set_pins(1'b0, 1'b1, 1'b0);
    @(posedge clk);
    strap <= 1'b1;
    settle();
    chk_mode(4'b0011);
    encode(8);
    u_host.set_pins(1'b1, 1'b0, 1'b1);
    settle();
    chk_mode(4'b1100);
    pipe_q.delete();
    u_host.set_pins(1'b1, 1'b0, 1'b0);
    settle();
    chk_mode(4'b1000);
    encode(8);
    chk(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule

/* adc_map.svh */
`ifndef ADC_MAP_SVH
`define ADC_MAP_SVH

// Widths
`define SAMPLE_W      14
`define HALF_W        7
`define REG_W         8
`define ADDR_W        7
`define CFG_W         7
`define PIN_W         6

// Serial frame: read/write flag, address, then data
`define CNT_W         5
`define CNT_ZERO      5'h00
`define CNT_ONE       5'h01
`define CNT_ADDR_LAST 5'h07
`define CNT_DATA_FIRST 5'h08
`define CNT_DATA_LAST 5'h0f
`define CNT_DONE      5'h10

// Mode control register addresses
`define ADDR_RESET    7'h00
`define ADDR_POWER    7'h01
`define ADDR_CLOCK    7'h02
`define ADDR_OUTPUT   7'h03

// Field positions
`define F_SOFT_RST    7
`define F_SLEEP       0
`define F_DCS         0
`define F_PHASE_LO    1
`define F_PHASE_HI    2
`define F_MODE_LO     0
`define F_MODE_HI     1
`define F_HICUR       2

// Reset values
`define REG_RST       8'h00
`define CFG_RST       7'h00

// Sample pipeline and output clock phase taps
`define PIPE_LAT      5
`define PHASE_TAPS    4

`endif

/* adc_pkg.sv */
package adc_pkg;

  typedef enum logic [1:0] {
    OUT_CMOS_FULL = 2'b00,
    OUT_CMOS_DDR  = 2'b01,
    OUT_LVDS_DDR  = 2'b10
  } out_mode_e;

  typedef struct packed {
    logic       dcs_en;
    logic       sleep;
    out_mode_e  mode;
    logic       lvds_hicur;
    logic [1:0] clk_phase;
  } cfg_s;

  typedef struct packed {
    logic        range;
    logic [13:0] data;
  } sample_s;

endpackage

/* spi_mode_port.sv */
`timescale 1ns/1ps
`include "adc_map.svh"
module spi_mode_port (
  input  wire logic              sck_in,
  input  wire logic              cs_b_in,
  input  wire logic              sdi_in,
  input  wire logic              rst_b_in,
  output logic [`CFG_W-1:0]      cfg_out,
  output logic                   sdo_pull_out
);

  logic [`CNT_W-1:0]  cnt_reg;
  logic               rw_reg;
  logic [`ADDR_W-1:0] addr_reg;
  logic [`REG_W-1:0]  shift_reg;
  logic [`REG_W-1:0]  rd_shift_reg;
  logic [`REG_W-1:0]  pwr_reg;
  logic [`REG_W-1:0]  clk_reg;
  logic [`REG_W-1:0]  out_reg;
  logic [`REG_W-1:0]  wdata;
  logic [`REG_W-1:0]  rd_word;
  logic               wr_en;
  logic               soft_rst;
  adc_pkg::cfg_s      cfg;

  // Register readback decode
  function automatic logic [`REG_W-1:0] reg_read(
    input logic [`ADDR_W-1:0] a,
    input logic [`REG_W-1:0]  p,
    input logic [`REG_W-1:0]  c,
    input logic [`REG_W-1:0]  o
  );
    case (a)
      `ADDR_POWER:  reg_read = p;
      `ADDR_CLOCK:  reg_read = c;
      `ADDR_OUTPUT: reg_read = o;
      default:      reg_read = `REG_RST;
    endcase
  endfunction

  // Write strobe on the last data bit of a write frame
  assign wdata    = {shift_reg[`REG_W-2:0], sdi_in};
  assign wr_en    = !cs_b_in && !rw_reg && (cnt_reg == `CNT_DATA_LAST);
  assign soft_rst = wr_en && (addr_reg == `ADDR_RESET) && wdata[`F_SOFT_RST];
  assign rd_word  = reg_read(addr_reg, pwr_reg, clk_reg, out_reg);

  // Frame shifter, cleared whenever chip select is high
  always_ff @(posedge sck_in or negedge rst_b_in or posedge cs_b_in) begin
    if (!rst_b_in) begin
      cnt_reg   <= `CNT_ZERO;
      rw_reg    <= 1'b0;
      addr_reg  <= {`ADDR_W{1'b0}};
      shift_reg <= `REG_RST;
    end else if (cs_b_in) begin
      cnt_reg   <= `CNT_ZERO;
      rw_reg    <= 1'b0;
      addr_reg  <= {`ADDR_W{1'b0}};
      shift_reg <= `REG_RST;
    end else if (cnt_reg != `CNT_DONE) begin
      shift_reg <= wdata;
      cnt_reg   <= cnt_reg + `CNT_ONE;
      if (cnt_reg == `CNT_ZERO)
        rw_reg <= sdi_in;
      if (cnt_reg == `CNT_ADDR_LAST)
        addr_reg <= {shift_reg[`ADDR_W-2:0], sdi_in};
    end
  end

  // Mode control registers
  always_ff @(posedge sck_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwr_reg <= `REG_RST;
      clk_reg <= `REG_RST;
      out_reg <= `REG_RST;
    end else if (soft_rst) begin
      pwr_reg <= `REG_RST;
      clk_reg <= `REG_RST;
      out_reg <= `REG_RST;
    end else if (wr_en) begin
      if (addr_reg == `ADDR_POWER)
        pwr_reg <= wdata;
      if (addr_reg == `ADDR_CLOCK)
        clk_reg <= wdata;
      if (addr_reg == `ADDR_OUTPUT)
        out_reg <= wdata;
    end
  end

  // Readback, MSB first, launched on falling SCK; pull low for zero
  always_ff @(negedge sck_in or negedge rst_b_in or posedge cs_b_in) begin
    if (!rst_b_in) begin
      rd_shift_reg <= `REG_RST;
      sdo_pull_out <= 1'b0;
    end else if (cs_b_in) begin
      rd_shift_reg <= `REG_RST;
      sdo_pull_out <= 1'b0;
    end else if (rw_reg && cnt_reg == `CNT_DATA_FIRST) begin
      sdo_pull_out <= !rd_word[`REG_W-1];
      rd_shift_reg <= {rd_word[`REG_W-2:0], 1'b1};
    end else if (rw_reg && cnt_reg > `CNT_DATA_FIRST
                 && cnt_reg != `CNT_DONE) begin
      sdo_pull_out <= !rd_shift_reg[`REG_W-1];
      rd_shift_reg <= {rd_shift_reg[`REG_W-2:0], 1'b1};
    end else begin
      sdo_pull_out <= 1'b0;
    end
  end

  // Configuration fields
  assign cfg.dcs_en     = clk_reg[`F_DCS];
  assign cfg.clk_phase  = clk_reg[`F_PHASE_HI:`F_PHASE_LO];
  assign cfg.sleep      = pwr_reg[`F_SLEEP];
  assign cfg.mode       = adc_pkg::out_mode_e'(out_reg[`F_MODE_HI:`F_MODE_LO]);
  assign cfg.lvds_hicur = out_reg[`F_HICUR];
  assign cfg_out        = cfg;

endmodule

/* sync_bits.sv */
`timescale 1ns/1ps
module sync_bits #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  // Two flops per bit; first flop feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          meta_reg[i] <= 1'b0;
          q_out[i]    <= 1'b0;
        end else begin
          meta_reg[i] <= d_in[i];
          q_out[i]    <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule
